// ==== design/mat_cam.sv ====
// Content match over a table of keys, with a first-free-slot finder.
// Assumes keys are packed entry 0 in the low bits; purely combinational.
`timescale 1ns/1ps

module mat_cam #(
  parameter int N  = 8,
  parameter int W  = 48,
  parameter int IW = (N > 1) ? $clog2(N) : 1
) (
  // Table contents
  input  wire logic [N*W-1:0] i_keys,
  input  wire logic [N-1:0]   i_vld,
  // Search key
  input  wire logic [W-1:0]   i_key,
  // Results
  output logic                o_hit,
  output logic [IW-1:0]       o_idx,
  output logic                o_free,
  output logic [IW-1:0]       o_free_idx
);

  logic [N-1:0] match;

  for (genvar g = 0; g < N; g++) begin : g_match
    assign match[g] = i_vld[g] && (i_keys[g*W +: W] == i_key);
  end

  // Lowest index wins so duplicates never give an ambiguous result.
  always_comb begin
    o_hit      = 1'b0;
    o_idx      = '0;
    o_free     = 1'b0;
    o_free_idx = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (match[i]) begin
        o_hit = 1'b1;
        o_idx = IW'(i);
      end
      if (!i_vld[i]) begin
        o_free     = 1'b1;
        o_free_idx = IW'(i);
      end
    end
  end

endmodule // mat_cam

// ==== design/mat_consts.svh ====
// Constants for the MAC address table: sizes, field positions and keys.
// Assumes it is included by the package only; the design files do not include it.
// Functional notes
// [R1] Static entries survive link loss and never age.
// [R2] Static entry forwards immediately when station returns.
// [R3] Static entry pins one address to one port.
// [R4] Management adds, moves and deletes static entries.
// [R5] Frames with filtered addresses are dropped.
// [R6] Management inserts and deletes filter addresses.
// [R7] Report lists a port's entries with types.
// [R8] Clear removes only that port's dynamic entries.
// [R9] Known groups forward only to member ports.
// [R10] Group keys must be class D addresses.
// [R11] Each group holds a per-port member set.
// [R12] Unknown multicast floods like broadcast.
// [R13] Learn source address unless static or filtered.
// [R14] Filter beats static, static beats dynamic.
`ifndef MAT_CONSTS_SVH
`define MAT_CONSTS_SVH

`define MAT_PORTS        8
`define MAT_TABLE_DEPTH  32
`define MAT_FILTER_DEPTH 8
`define MAT_GROUP_DEPTH  8
`define MAT_MAC_W        48
`define MAT_IP_W         32
`define MAT_MAC_GRP_BIT  40
`define MAT_CLASSD_TOP   4'hE
`define MAT_CLASSD_LO    32'hE000_0000
`define MAT_CLASSD_HI    32'hEFFF_FFFF

`endif

// ==== design/mat_device.sv ====
// Address table end: forwarding lookups, learning, filter and group lists.
// Assumes one lookup per cycle at most and a client that holds requests.
`timescale 1ns/1ps

module mat_device
  import mat_pkg::*;
#(
  parameter int P = `MAT_PORTS,
  parameter int D = `MAT_TABLE_DEPTH,
  parameter int F = `MAT_FILTER_DEPTH,
  parameter int G = `MAT_GROUP_DEPTH
) (
  // Clock and reset
  input  wire logic         i_mclk,
  input  wire logic         i_rst,
  // Port link state
  input  wire logic [P-1:0] i_link_up,
  // Status
  output logic              o_table_full,
  // Link to the client
  mat_if.dev                bus
);

  localparam int PW = (P > 1) ? $clog2(P) : 1;
  localparam int DW = (D > 1) ? $clog2(D) : 1;
  localparam int FW = (F > 1) ? $clog2(F) : 1;
  localparam int GW = (G > 1) ? $clog2(G) : 1;
  localparam int MW = `MAT_MAC_W;
  localparam int AW = `MAT_IP_W;

  // Address table.
  logic [D-1:0]          tv_q, tv_d, ts_q, ts_d;
  logic [D-1:0][MW-1:0]  tmac_q, tmac_d;
  logic [D-1:0][PW-1:0]  tport_q, tport_d;
  // Filter list and group table.
  logic [F-1:0]          fv_q, fv_d;
  logic [F-1:0][MW-1:0]  fmac_q, fmac_d;
  logic [G-1:0]          gv_q, gv_d;
  logic [G-1:0][AW-1:0]  gip_q, gip_d;
  logic [G-1:0][P-1:0]   gmem_q, gmem_d;
  // Control and outputs.
  mat_dev_state_t        st_q, st_d;
  logic [DW-1:0]         rix_q, rix_d;
  logic [PW-1:0]         sel_q, sel_d;
  logic                  rs_valid_q, rs_valid_d, rs_drop_q, rs_drop_d;
  logic [P-1:0]          rs_ports_q, rs_ports_d;
  logic                  done_q, done_d, ok_q, ok_d;
  logic                  rp_valid_q, rp_valid_d, rp_static_q, rp_static_d;
  logic [MW-1:0]         rp_mac_q, rp_mac_d;
  logic                  full_q, full_d;

  logic                  lk_take, mg_take;
  logic                  td_hit, ts_hit, tm_hit, t_free;
  logic [DW-1:0]         td_idx, ts_idx, tm_idx, t_free_idx;
  logic                  fd_hit, fs_hit, fm_hit, f_free;
  logic [FW-1:0]         fm_idx, f_free_idx;
  logic                  gl_hit, gm_hit, g_free;
  logic [GW-1:0]         gl_idx, gm_idx, g_free_idx;
  logic                  wr_en, wr_st, del_en, clr_en;
  logic [DW-1:0]         wr_idx, del_idx;
  logic [MW-1:0]         wr_mac;
  logic [PW-1:0]         wr_port;
  logic                  learn_en;
  logic [P-1:0]          in_mask;

  assign bus.lk_ready  = (st_q == MAT_ST_IDLE);
  // Lookups own the table in their cycle; management waits for a gap.
  assign bus.mg_ready  = (st_q == MAT_ST_IDLE) && !bus.lk_valid;
  assign lk_take       = bus.lk_valid && bus.lk_ready;
  assign mg_take       = bus.mg_valid && bus.mg_ready;
  assign bus.rs_valid  = rs_valid_q;
  assign bus.rs_drop   = rs_drop_q;
  assign bus.rs_ports  = rs_ports_q;
  assign bus.mg_done   = done_q;
  assign bus.mg_ok     = ok_q;
  assign bus.rp_valid  = rp_valid_q;
  assign bus.rp_static = rp_static_q;
  assign bus.rp_mac    = rp_mac_q;
  assign o_table_full  = full_q;

  mat_cam #(.N(D), .W(MW)) u_td (.i_keys(tmac_q), .i_vld(tv_q),
    .i_key(bus.lk_dst_mac), .o_hit(td_hit), .o_idx(td_idx),
    .o_free(t_free), .o_free_idx(t_free_idx));
  mat_cam #(.N(D), .W(MW)) u_ts (.i_keys(tmac_q), .i_vld(tv_q),
    .i_key(bus.lk_src_mac), .o_hit(ts_hit), .o_idx(ts_idx),
    .o_free(), .o_free_idx());
  mat_cam #(.N(D), .W(MW)) u_tm (.i_keys(tmac_q), .i_vld(tv_q),
    .i_key(bus.mg_mac), .o_hit(tm_hit), .o_idx(tm_idx),
    .o_free(), .o_free_idx());
  mat_cam #(.N(F), .W(MW)) u_fd (.i_keys(fmac_q), .i_vld(fv_q),
    .i_key(bus.lk_dst_mac), .o_hit(fd_hit), .o_idx(),
    .o_free(), .o_free_idx());
  mat_cam #(.N(F), .W(MW)) u_fs (.i_keys(fmac_q), .i_vld(fv_q),
    .i_key(bus.lk_src_mac), .o_hit(fs_hit), .o_idx(),
    .o_free(), .o_free_idx());
  mat_cam #(.N(F), .W(MW)) u_fm (.i_keys(fmac_q), .i_vld(fv_q),
    .i_key(bus.mg_mac), .o_hit(fm_hit), .o_idx(fm_idx),
    .o_free(f_free), .o_free_idx(f_free_idx));
  mat_cam #(.N(G), .W(AW)) u_gl (.i_keys(gip_q), .i_vld(gv_q),
    .i_key(bus.lk_group_ip), .o_hit(gl_hit), .o_idx(gl_idx),
    .o_free(), .o_free_idx());
  mat_cam #(.N(G), .W(AW)) u_gm (.i_keys(gip_q), .i_vld(gv_q),
    .i_key(bus.mg_ip), .o_hit(gm_hit), .o_idx(gm_idx),
    .o_free(g_free), .o_free_idx(g_free_idx));

  // Per-entry update of the address table.
  for (genvar g = 0; g < D; g++) begin : g_entry
    logic kill, hit;
    // Dynamic entries go on link loss or a port clear; static ones go only on a delete command.
    assign kill = (del_en && del_idx == DW'(g)) ||
                  (!ts_q[g] && (!i_link_up[tport_q[g]] ||                 // R1
                   (clr_en && tport_q[g] == bus.mg_port)));              // R8
    assign hit        = wr_en && (wr_idx == DW'(g));
    assign tv_d[g]    = hit || (tv_q[g] && !kill);
    assign ts_d[g]    = hit ? wr_st : ts_q[g];
    assign tmac_d[g]  = hit ? wr_mac : tmac_q[g];
    assign tport_d[g] = hit ? wr_port : tport_q[g];
  end

  // Forwarding decision for the lookup taken this cycle.
  always_comb begin
    in_mask    = {{(P-1){1'b0}}, 1'b1} << bus.lk_src_port;
    rs_valid_d = lk_take;
    rs_drop_d  = 1'b0;
    rs_ports_d = '1;
    if (fd_hit || fs_hit) begin
      rs_drop_d  = 1'b1;                                                 // R5
      rs_ports_d = '0;                                                   // R14
    end else if (bus.lk_dst_mac[`MAT_MAC_GRP_BIT]) begin
      if (bus.lk_ip_mcast && mat_is_class_d(bus.lk_group_ip) && gl_hit)
        rs_ports_d = gmem_q[gl_idx];                                     // R9
      else
        rs_ports_d = '1;                                                 // R12
    end else if (td_hit) begin
      // Known station is sent to its bound port, linked or not.
      rs_ports_d = {{(P-1){1'b0}}, 1'b1} << tport_q[td_idx];        // R2 R3
    end
    rs_ports_d = rs_ports_d & ~in_mask;
  end

  // Learning and management commands.
  always_comb begin
    learn_en = lk_take && !fs_hit && !bus.lk_src_mac[`MAT_MAC_GRP_BIT] &&
               !(ts_hit && ts_q[ts_idx]);                               // R13
    wr_en    = 1'b0;
    wr_st    = 1'b0;
    wr_idx   = ts_hit ? ts_idx : t_free_idx;
    wr_mac   = bus.lk_src_mac;
    wr_port  = bus.lk_src_port;
    del_en   = 1'b0;
    del_idx  = tm_idx;
    clr_en   = 1'b0;
    fv_d     = fv_q;
    fmac_d   = fmac_q;
    gv_d     = gv_q;
    gip_d    = gip_q;
    gmem_d   = gmem_q;
    st_d     = st_q;
    rix_d    = rix_q;
    sel_d    = sel_q;
    done_d   = 1'b0;
    ok_d     = 1'b0;
    full_d   = full_q;
    rp_valid_d  = 1'b0;
    rp_static_d = 1'b0;
    rp_mac_d    = rp_mac_q;
    if (learn_en) begin
      wr_en  = ts_hit || t_free;
      full_d = !ts_hit && !t_free;
    end
    if (mg_take) begin
      done_d  = 1'b1;
      wr_mac  = bus.mg_mac;
      wr_port = bus.mg_port;
      wr_st   = 1'b1;
      wr_idx  = tm_hit ? tm_idx : t_free_idx;
      case (bus.mg_op)
        MAT_OP_ADD_STATIC: begin
          // An existing entry for the address is turned static or moved.
          wr_en = tm_hit || t_free;                                   // R4 R14
          ok_d  = tm_hit || t_free;
        end
        MAT_OP_DEL_STATIC: begin
          del_en = tm_hit && ts_q[tm_idx];                               // R4
          ok_d   = tm_hit && ts_q[tm_idx];
        end
        MAT_OP_ADD_FILTER: begin
          ok_d = fm_hit || f_free;
          if (!fm_hit && f_free) begin
            fv_d[f_free_idx]   = 1'b1;                                   // R6
            fmac_d[f_free_idx] = bus.mg_mac;
          end
        end
        MAT_OP_DEL_FILTER: begin
          ok_d = fm_hit;
          if (fm_hit)
            fv_d[fm_idx] = 1'b0;                                         // R6
        end
        MAT_OP_SET_GROUP: begin
          if (mat_is_class_d(bus.mg_ip)) begin                          // R10
            ok_d = gm_hit || g_free;
            if (gm_hit) begin
              gmem_d[gm_idx] = bus.mg_members;                          // R11
            end else if (g_free) begin
              gv_d[g_free_idx]   = 1'b1;
              gip_d[g_free_idx]  = bus.mg_ip;
              gmem_d[g_free_idx] = bus.mg_members;                      // R11
            end
          end
        end
        MAT_OP_DEL_GROUP: begin
          ok_d = gm_hit;
          if (gm_hit)
            gv_d[gm_idx] = 1'b0;
        end
        MAT_OP_CLEAR_DYN: begin
          clr_en = 1'b1;                                                 // R8
          ok_d   = 1'b1;
          full_d = 1'b0;
        end
        MAT_OP_REPORT: begin
          done_d = 1'b0;
          st_d   = MAT_ST_REPORT;
          rix_d  = '0;
          sel_d  = bus.mg_port;
        end
        default: begin
          ok_d = 1'b0;
        end
      endcase
    end
    case (st_q)
      MAT_ST_IDLE: begin
      end
      MAT_ST_REPORT: begin
        // One entry is examined per cycle; lookups are held off meanwhile.
        rp_valid_d  = tv_q[rix_q] && (tport_q[rix_q] == sel_q);          // R7
        rp_static_d = ts_q[rix_q];                                       // R7
        rp_mac_d    = tmac_q[rix_q];
        rix_d       = rix_q + 1'b1;
        if (rix_q == DW'(D - 1)) begin
          st_d   = MAT_ST_IDLE;
          done_d = 1'b1;
          ok_d   = 1'b1;
        end
      end
      default: begin
        st_d = MAT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      tv_q        <= '0;
      ts_q        <= '0;
      tmac_q      <= '0;
      tport_q     <= '0;
      fv_q        <= '0;
      fmac_q      <= '0;
      gv_q        <= '0;
      gip_q       <= '0;
      gmem_q      <= '0;
      st_q        <= MAT_ST_IDLE;
      rix_q       <= '0;
      sel_q       <= '0;
      rs_valid_q  <= 1'b0;
      rs_drop_q   <= 1'b0;
      rs_ports_q  <= '0;
      done_q      <= 1'b0;
      ok_q        <= 1'b0;
      rp_valid_q  <= 1'b0;
      rp_static_q <= 1'b0;
      rp_mac_q    <= '0;
      full_q      <= 1'b0;
    end else begin
      tv_q        <= tv_d;
      ts_q        <= ts_d;
      tmac_q      <= tmac_d;
      tport_q     <= tport_d;
      fv_q        <= fv_d;
      fmac_q      <= fmac_d;
      gv_q        <= gv_d;
      gip_q       <= gip_d;
      gmem_q      <= gmem_d;
      st_q        <= st_d;
      rix_q       <= rix_d;
      sel_q       <= sel_d;
      rs_valid_q  <= rs_valid_d;
      rs_drop_q   <= rs_drop_d;
      rs_ports_q  <= rs_ports_d;
      done_q      <= done_d;
      ok_q        <= ok_d;
      rp_valid_q  <= rp_valid_d;
      rp_static_q <= rp_static_d;
      rp_mac_q    <= rp_mac_d;
      full_q      <= full_d;
    end
  end

endmodule // mat_device

// ==== design/mat_host.sv ====
// Client end: passes lookups through and sequences management commands.
// Assumes the user holds a command until o_cmd_ready and waits for done.
`timescale 1ns/1ps

module mat_host
  import mat_pkg::*;
#(
  parameter int P  = `MAT_PORTS,
  parameter int PW = (P > 1) ? $clog2(P) : 1
) (
  // Clock and reset
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  // Lookup request
  input  wire logic                 i_lk_valid,
  output logic                      o_lk_ready,
  input  wire logic [`MAT_MAC_W-1:0] i_lk_dst_mac,
  input  wire logic [`MAT_MAC_W-1:0] i_lk_src_mac,
  input  wire logic [PW-1:0]        i_lk_src_port,
  input  wire logic                 i_lk_ip_mcast,
  input  wire logic [`MAT_IP_W-1:0]  i_lk_group_ip,
  // Lookup result
  output logic                      o_rs_valid,
  output logic                      o_rs_drop,
  output logic [P-1:0]              o_rs_ports,
  // Management command
  input  wire logic                 i_cmd_valid,
  output logic                      o_cmd_ready,
  input  wire mat_op_t              i_cmd_op,
  input  wire logic [`MAT_MAC_W-1:0] i_cmd_mac,
  input  wire logic [PW-1:0]        i_cmd_port,
  input  wire logic [`MAT_IP_W-1:0]  i_cmd_ip,
  input  wire logic [P-1:0]         i_cmd_members,
  // Management answer and report stream
  output logic                      o_cmd_done,
  output logic                      o_cmd_ok,
  output logic                      o_rp_valid,
  output logic                      o_rp_static,
  output logic [`MAT_MAC_W-1:0]      o_rp_mac,
  // Link to the table
  mat_if.host                       bus
);

  mat_host_state_t        st_q, st_d;
  mat_op_t                op_q, op_d;
  logic [`MAT_MAC_W-1:0]  mac_q, mac_d, rp_mac_q, rp_mac_d;
  logic [PW-1:0]          port_q, port_d;
  logic [`MAT_IP_W-1:0]   ip_q, ip_d;
  logic [P-1:0]           mem_q, mem_d, rs_ports_q, rs_ports_d;
  logic                   done_q, done_d, ok_q, ok_d;
  logic                   rs_valid_q, rs_valid_d, rs_drop_q, rs_drop_d;
  logic                   rp_valid_q, rp_valid_d, rp_st_q, rp_st_d;
  logic                   group_op;

  assign o_lk_ready      = bus.lk_ready;
  assign bus.lk_valid    = i_lk_valid;
  assign bus.lk_dst_mac  = i_lk_dst_mac;
  assign bus.lk_src_mac  = i_lk_src_mac;
  assign bus.lk_src_port = i_lk_src_port;
  assign bus.lk_ip_mcast = i_lk_ip_mcast;
  assign bus.lk_group_ip = i_lk_group_ip;
  assign bus.mg_valid    = (st_q == MAT_HS_SEND);
  assign bus.mg_op       = op_q;
  assign bus.mg_mac      = mac_q;
  assign bus.mg_port     = port_q;
  assign bus.mg_ip       = ip_q;
  assign bus.mg_members  = mem_q;
  assign o_cmd_ready     = (st_q == MAT_HS_IDLE) && !done_q;
  assign o_cmd_done      = done_q;
  assign o_cmd_ok        = ok_q;
  assign o_rs_valid      = rs_valid_q;
  assign o_rs_drop       = rs_drop_q;
  assign o_rs_ports      = rs_ports_q;
  assign o_rp_valid      = rp_valid_q;
  assign o_rp_static     = rp_st_q;
  assign o_rp_mac        = rp_mac_q;
  assign group_op = (i_cmd_op == MAT_OP_SET_GROUP) ||
                    (i_cmd_op == MAT_OP_DEL_GROUP);

  always_comb begin
    st_d       = st_q;
    op_d       = op_q;
    mac_d      = mac_q;
    port_d     = port_q;
    ip_d       = ip_q;
    mem_d      = mem_q;
    done_d     = 1'b0;
    ok_d       = 1'b0;
    rs_valid_d = bus.rs_valid;
    rs_drop_d  = bus.rs_drop;
    rs_ports_d = bus.rs_ports;
    rp_valid_d = bus.rp_valid;
    rp_st_d    = bus.rp_static;
    rp_mac_d   = bus.rp_valid ? bus.rp_mac : rp_mac_q;
    case (st_q)
      MAT_HS_IDLE: begin
        if (i_cmd_valid && o_cmd_ready) begin
          op_d   = i_cmd_op;
          mac_d  = i_cmd_mac;
          port_d = i_cmd_port;
          ip_d   = i_cmd_ip;
          mem_d  = i_cmd_members;                                       // R11
          // Non class D group keys never reach the table.
          if (group_op && !mat_is_class_d(i_cmd_ip))                    // R10
            done_d = 1'b1;
          else
            st_d = MAT_HS_SEND;                                       // R4 R6
        end
      end
      MAT_HS_SEND: begin
        if (bus.mg_ready)
          st_d = MAT_HS_WAIT;
      end
      MAT_HS_WAIT: begin
        if (bus.mg_done) begin
          st_d   = MAT_HS_IDLE;
          done_d = 1'b1;
          ok_d   = bus.mg_ok;
        end
      end
      default: begin
        st_d = MAT_HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q       <= MAT_HS_IDLE;
      op_q       <= MAT_OP_ADD_STATIC;
      mac_q      <= '0;
      port_q     <= '0;
      ip_q       <= '0;
      mem_q      <= '0;
      done_q     <= 1'b0;
      ok_q       <= 1'b0;
      rs_valid_q <= 1'b0;
      rs_drop_q  <= 1'b0;
      rs_ports_q <= '0;
      rp_valid_q <= 1'b0;
      rp_st_q    <= 1'b0;
      rp_mac_q   <= '0;
    end else begin
      st_q       <= st_d;
      op_q       <= op_d;
      mac_q      <= mac_d;
      port_q     <= port_d;
      ip_q       <= ip_d;
      mem_q      <= mem_d;
      done_q     <= done_d;
      ok_q       <= ok_d;
      rs_valid_q <= rs_valid_d;
      rs_drop_q  <= rs_drop_d;
      rs_ports_q <= rs_ports_d;
      rp_valid_q <= rp_valid_d;
      rp_st_q    <= rp_st_d;
      rp_mac_q   <= rp_mac_d;
    end
  end

endmodule // mat_host

// ==== design/mat_if.sv ====
// Link between the address table and its datapath and management client.
// Assumes both ends run on one clock; no clocking block is used.
`timescale 1ns/1ps

interface mat_if
  import mat_pkg::*;
#(
  parameter int P = `MAT_PORTS
);
  localparam int PW = (P > 1) ? $clog2(P) : 1;

  logic                 lk_valid;
  logic                 lk_ready;
  logic [`MAT_MAC_W-1:0] lk_dst_mac;
  logic [`MAT_MAC_W-1:0] lk_src_mac;
  logic [PW-1:0]        lk_src_port;
  logic                 lk_ip_mcast;
  logic [`MAT_IP_W-1:0]  lk_group_ip;
  logic                 rs_valid;
  logic                 rs_drop;
  logic [P-1:0]         rs_ports;
  logic                 mg_valid;
  logic                 mg_ready;
  mat_op_t              mg_op;
  logic [`MAT_MAC_W-1:0] mg_mac;
  logic [PW-1:0]        mg_port;
  logic [`MAT_IP_W-1:0]  mg_ip;
  logic [P-1:0]         mg_members;
  logic                 mg_done;
  logic                 mg_ok;
  logic                 rp_valid;
  logic                 rp_static;
  logic [`MAT_MAC_W-1:0] rp_mac;

  modport dev (
    input  lk_valid, lk_dst_mac, lk_src_mac, lk_src_port, lk_ip_mcast,
    input  lk_group_ip, mg_valid, mg_op, mg_mac, mg_port, mg_ip,
    input  mg_members,
    output lk_ready, rs_valid, rs_drop, rs_ports, mg_ready, mg_done,
    output mg_ok, rp_valid, rp_static, rp_mac
  );

  modport host (
    output lk_valid, lk_dst_mac, lk_src_mac, lk_src_port, lk_ip_mcast,
    output lk_group_ip, mg_valid, mg_op, mg_mac, mg_port, mg_ip,
    output mg_members,
    input  lk_ready, rs_valid, rs_drop, rs_ports, mg_ready, mg_done,
    input  mg_ok, rp_valid, rp_static, rp_mac
  );

endinterface

// ==== design/mat_pkg.sv ====
// Types shared by both ends of the MAC address table link.
// Assumes mat_consts.svh is on the include path.
`include "mat_consts.svh"

package mat_pkg;

  typedef enum logic [2:0] {
    MAT_OP_ADD_STATIC,
    MAT_OP_DEL_STATIC,
    MAT_OP_ADD_FILTER,
    MAT_OP_DEL_FILTER,
    MAT_OP_SET_GROUP,
    MAT_OP_DEL_GROUP,
    MAT_OP_CLEAR_DYN,
    MAT_OP_REPORT
  } mat_op_t;

  typedef enum logic {
    MAT_ST_IDLE,
    MAT_ST_REPORT
  } mat_dev_state_t;

  typedef enum logic [1:0] {
    MAT_HS_IDLE,
    MAT_HS_SEND,
    MAT_HS_WAIT
  } mat_host_state_t;

  function automatic logic mat_is_class_d(
    input logic [`MAT_IP_W-1:0] ip
  );
    return (ip >= `MAT_CLASSD_LO) && (ip <= `MAT_CLASSD_HI);
  endfunction

endpackage

// ==== test/mat_props.sv ====
// Checker for the link between the host and device ends of the table.
// Assumes one clock with a synchronous active-high reset.
`timescale 1ns/1ps

module mat_props
  import mat_pkg::*;
#(
  parameter int P  = 8,
  parameter int D  = 32,
  parameter int PW = 3
) (
  // Clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  // Lookup side
  input  wire logic            lk_valid,
  input  wire logic            lk_ready,
  input  wire logic [47:0]     lk_dst_mac,
  input  wire logic            lk_ip_mcast,
  input  wire logic [PW-1:0]   lk_src_port,
  input  wire logic            rs_valid,
  input  wire logic            rs_drop,
  input  wire logic [P-1:0]    rs_ports,
  // Management side
  input  wire logic            mg_valid,
  input  wire logic            mg_ready,
  input  wire mat_op_t         mg_op,
  input  wire logic [31:0]     mg_ip,
  input  wire logic            mg_done,
  input  wire logic            rp_valid
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  rs_follows_a: assert property (lk_valid && lk_ready |=> rs_valid)
    else $error("no result");
  ingress_clear_a: assert property (rs_valid |->
    !rs_ports[$past(lk_src_port)]) else $error("ingress port in mask");
  drop_mask_a: assert property (rs_valid && rs_drop |-> rs_ports == '0)
    else $error("drop with ports");
  mc_flood_a: assert property (lk_valid && lk_ready && lk_dst_mac[40] &&
    !lk_ip_mcast |=> rs_drop || (rs_ports | (P'(1) << $past(lk_src_port)))
    == '1) else $error("mcast not flooded");
  group_key_a: assert property (mg_valid && mg_op inside {MAT_OP_SET_GROUP,
    MAT_OP_DEL_GROUP} |-> mg_ip[31:28] == 4'hE) else $error("bad group key");
  cmd_done_a: assert property (mg_valid && mg_ready &&
    mg_op != MAT_OP_REPORT |=> mg_done) else $error("no done");
  report_len_a: assert property (mg_valid && mg_ready &&
    mg_op == MAT_OP_REPORT |-> ##(D+1) mg_done) else $error("report length");
  report_block_a: assert property (rp_valid && !mg_done |-> !lk_ready)
    else $error("lookup open in report");
  mgmt_yield_a: assert property (lk_valid |-> !mg_ready)
    else $error("command beside lookup");
endmodule // mat_props

// ==== test/tb_mac_address_table_filter.sv ====
// Bench for both table ends: lookups, commands and reports.
// Assumes the package is compiled first.
`timescale 1ns/1ps

module tb_mac_address_table_filter
  import mat_pkg::*;
;
  localparam logic [47:0] A = 48'h0010_0000_00A1, B = 48'h0010_0000_00B2;
  localparam logic [47:0] C = 48'h0010_0000_00C3, S = 48'h0010_0000_00D0;
  localparam logic [47:0] M = 48'h0100_5E00_0001, Z = 48'h0;
  logic        mclk, rst, lk_v, c_v, mc;
  logic [2:0]  sport, cport;
  logic [7:0]  link, mem;
  logic [31:0] gip, cip;
  logic [47:0] dst, src, cmac, rnd;
  mat_op_t     cop;
  wire logic   lk_rdy, rs_v, rs_drop, c_rdy, c_done, c_ok, rp_v, rp_st;
  wire logic [7:0]  rs_ports;
  wire logic [47:0] rp_mac;
  logic [8:0]  rs_q[$];
  logic        ok_q[$];
  logic [48:0] rp_q[$];
  int          error_cnt = 0, checks = 0, cyc = 0;

  mat_if #(.P(8)) bus ();
  mat_device i_mat_device (.i_mclk(mclk), .i_rst(rst), .i_link_up(link),
    .o_table_full(), .bus(bus));
  mat_host i_mat_host (.i_mclk(mclk), .i_rst(rst), .i_lk_valid(lk_v),
    .o_lk_ready(lk_rdy), .i_lk_dst_mac(dst), .i_lk_src_mac(src),
    .i_lk_src_port(sport), .i_lk_ip_mcast(mc), .i_lk_group_ip(gip),
    .o_rs_valid(rs_v), .o_rs_drop(rs_drop), .o_rs_ports(rs_ports),
    .i_cmd_valid(c_v), .o_cmd_ready(c_rdy), .i_cmd_op(cop),
    .i_cmd_mac(cmac), .i_cmd_port(cport), .i_cmd_ip(cip),
    .i_cmd_members(mem), .o_cmd_done(c_done), .o_cmd_ok(c_ok),
    .o_rp_valid(rp_v), .o_rp_static(rp_st), .o_rp_mac(rp_mac), .bus(bus));
  mat_props i_mat_props (.i_mclk(mclk), .i_rst(rst),
    .lk_valid(bus.lk_valid), .lk_ready(bus.lk_ready),
    .lk_dst_mac(bus.lk_dst_mac), .lk_ip_mcast(bus.lk_ip_mcast),
    .lk_src_port(bus.lk_src_port), .rs_valid(bus.rs_valid),
    .rs_drop(bus.rs_drop), .rs_ports(bus.rs_ports),
    .mg_valid(bus.mg_valid), .mg_ready(bus.mg_ready), .mg_op(bus.mg_op),
    .mg_ip(bus.mg_ip), .mg_done(bus.mg_done), .rp_valid(bus.rp_valid));

  task automatic chk(string what, logic [48:0] seen, logic [48:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic look(logic [47:0] d, s, logic [2:0] p, logic [8:0] e,
                      logic m = 1'b0, logic [31:0] g = '0);
    rs_q.push_back(e);
    {lk_v, dst, src, sport, mc, gip} <= {1'b1, d, s, p, m, g};
    @(posedge mclk);
    while (!lk_rdy) @(posedge mclk);
  endtask

  task automatic cmd(mat_op_t o, logic [47:0] a, logic [2:0] p, logic e,
                     logic [31:0] ip = '0, logic [7:0] m = '0);
    ok_q.push_back(e);
    cop <= o;
    {lk_v, c_v, cmac, cport, cip, mem} <= {2'b01, a, p, ip, m};
    @(posedge mclk);
    while (!c_rdy) @(posedge mclk);
    c_v <= 1'b0;
    while (ok_q.size()) @(posedge mclk);
    @(posedge mclk);
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // Compares each result with the oldest note.
  always @(posedge mclk) begin
    cyc++;
    if (rs_v === 1'b1)
      chk("result", {rs_drop, rs_ports}, rs_q.size() ? rs_q.pop_front() : 'x);
    if (c_done === 1'b1)
      chk("cmd ok", c_ok, ok_q.size() ? ok_q.pop_front() : 1'bx);
    if (rp_v === 1'b1)
      chk("entry", {rp_st, rp_mac}, rp_q.size() ? rp_q.pop_front() : 'x);
    if (cyc == 5000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    {rst, mc, sport, cport, mem, gip, cip, dst, src, cmac} = '1;
    {lk_v, c_v} = 2'b00;
    link = 8'hFF;
    cop = MAT_OP_REPORT;
    void'($urandom(32'h3d0c));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    cmd(MAT_OP_ADD_STATIC, A, 2, 1);
    link <= 8'hFB;
    look(A, S, 0, 9'h004);
    link <= 8'hFF;
    look(A, S, 0, 9'h004);
    cmd(MAT_OP_ADD_STATIC, A, 5, 1);
    look(A, S, 0, 9'h020);
    cmd(MAT_OP_DEL_STATIC, A, 5, 1);
    cmd(MAT_OP_DEL_STATIC, A, 5, 0);
    look(A, S, 0, 9'h0FE);
    $display("static test done");
    rnd = {8'h02, 8'($urandom), 32'($urandom)};
    look(rnd, B, 3, 9'h0F7);
    look(B, S, 0, 9'h008);
    cmd(MAT_OP_ADD_STATIC, B, 6, 1);
    look(B, S, 0, 9'h040);
    cmd(MAT_OP_ADD_FILTER, B, 0, 1);
    look(B, S, 0, 9'h100);
    cmd(MAT_OP_DEL_FILTER, B, 0, 1);
    cmd(MAT_OP_DEL_FILTER, B, 0, 0);
    look(B, S, 0, 9'h040);
    $display("filter test done");
    look(rnd, C, 6, 9'h0BF);
    rp_q = '{{1'b1, B}, {1'b0, C}};
    cmd(MAT_OP_REPORT, Z, 6, 1);
    cmd(MAT_OP_CLEAR_DYN, Z, 6, 1);
    rp_q = '{{1'b1, B}};
    cmd(MAT_OP_REPORT, Z, 6, 1);
    look(S, B, 6, 9'h001);
    $display("report test done");
    cmd(MAT_OP_SET_GROUP, Z, 0, 1, 32'hE000_0001, 8'h0F);
    look(M, S, 0, 9'h00E, 1, 32'hE000_0001);
    look(M, S, 0, 9'h0FE, 1, 32'hEFFF_FFFF);
    look(M, S, 0, 9'h0FE);
    cmd(MAT_OP_SET_GROUP, Z, 0, 0, 32'hF000_0000, 8'h80);
    cmd(MAT_OP_SET_GROUP, Z, 0, 1, 32'hEFFF_FFFF, 8'h80);
    look(M, S, 0, 9'h080, 1, 32'hEFFF_FFFF);
    cmd(MAT_OP_DEL_GROUP, Z, 0, 1, 32'hE000_0001);
    look(M, S, 0, 9'h0FE, 1, 32'hE000_0001);
    cmd(MAT_OP_DEL_GROUP, Z, 0, 0, 32'hDFFF_FFFF);
    $display("group test done");
    repeat (4) @(posedge mclk);
    chk("notes left", rs_q.size() + ok_q.size() + rp_q.size(), 0);
    close_out();
  end
endmodule // tb_mac_address_table_filter
